// >>> hw/ubd_consts.vh
// Purpose: Constants for the buffer descriptor logic block
// Assumes: APB slave, 12-bit byte address, 32-bit data
// Notes: One descriptor per aligned word in the table window
`ifndef UBD_CONSTS_VH
`define UBD_CONSTS_VH

// Register map (byte addresses)
`define UBD_ADDR_W 12
`define UBD_BDT_PAGE 4'h0
`define UBD_OFF_CONFIG 12'h100
`define UBD_OFF_XFER_STATUS 12'h104
`define UBD_OFF_POINTERS 12'h108

// Descriptor word byte lanes
`define UBD_W_STATUS 7:0
`define UBD_W_COUNT 15:8
`define UBD_W_ADDR 31:16

// Status byte bits
`define UBD_ST_OWN 7
`define UBD_ST_TOG 6
`define UBD_ST_KEEP 5
`define UBD_ST_STEP 4
`define UBD_ST_CHK 3
`define UBD_ST_HALT 2
`define UBD_ST_PID 5:2
`define UBD_ST_CNTH 1:0

// Configuration register fields
`define UBD_CFG_MODE 1:0
`define UBD_CFG_EN 2
`define UBD_CFG_PTR_RST 3
`define UBD_CFG_RESET 4'h0

// Ping-pong modes
`define UBD_MODE_NONE 2'h0
`define UBD_MODE_EP0OUT 2'h1
`define UBD_MODE_ALL 2'h2
`define UBD_MODE_NOT_EP0 2'h3

// Handshake codes
`define UBD_HS_ACK 2'h0
`define UBD_HS_NAK 2'h1
`define UBD_HS_STALL 2'h2

// Engine states
`define UBD_S_IDLE 2'h0
`define UBD_S_LOOK 2'h1
`define UBD_S_WB 2'h2

`endif

// >>> hw/ubd_core.v
// Purpose: Buffer descriptor handling between serial engine and CPU
// Assumes: Engine transaction inputs are synchronous to pclk
// Notes: Descriptor table lives here and is reached over APB
`include "ubd_consts.vh"

module ubd_core #(
	parameter NUM_BD = 64,
	parameter NUM_EP = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`UBD_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire tok_valid,
	input wire [3:0] tok_ep,
	input wire [3:0] tok_pid,
	input wire tok_in,
	input wire tok_setup,
	input wire [9:0] rx_count,
	input wire rx_toggle,
	input wire rx_error,
	output reg tok_ready,
	output reg hs_valid,
	output reg [1:0] hs_code,
	output reg [5:0] bd_index,
	output reg [15:0] bd_addr,
	output reg [9:0] bd_len,
	output reg bd_addr_step_disable
);

	// Descriptor table, no reset: contents undefined until written
	reg [31:0] descriptor_table [0:NUM_BD-1];
	reg [3:0] cfg; // Mode, enable, pointer reset
	reg [3:0] xs_ep; // Endpoint of last released transaction
	reg xs_dir; // Direction of last released transaction
	reg xs_parity; // Odd descriptor used last
	reg [NUM_EP-1:0] ptr_out; // Even/odd pointers, OUT side
	reg [NUM_EP-1:0] ptr_in; // Even/odd pointers, IN side
	reg [1:0] state; // Engine sequencer
	reg [3:0] t_ep; // Latched token
	reg [3:0] t_pid;
	reg t_in;
	reg t_setup;
	reg [9:0] t_rx;
	reg t_tog;
	reg t_err;
	reg [5:0] t_idx; // Descriptor chosen
	reg t_odd; // Pointer value used
	reg t_pp; // Direction is ping-ponged
	reg wb_do; // Write-back pending
	reg [31:0] wb_word; // Word to write back
	reg wb_release; // Ownership handed back

	// Bus decode
	wire apb_done = psel & penable & pready;
	wire apb_wr = apb_done & pwrite;
	wire in_bdt = (paddr[`UBD_ADDR_W-1:8] == `UBD_BDT_PAGE);
	wire [5:0] apb_idx = paddr[7:2];
	wire hit_cfg = (paddr == `UBD_OFF_CONFIG);
	wire hit_xs = (paddr == `UBD_OFF_XFER_STATUS);
	wire hit_ptr = (paddr == `UBD_OFF_POINTERS);
	wire mapped = in_bdt | hit_cfg | hit_xs | hit_ptr;
	wire [1:0] mode = cfg[`UBD_CFG_MODE];
	wire cfg_en_rise = apb_wr & hit_cfg & pstrb[0] & pwdata[`UBD_CFG_EN] & ~cfg[`UBD_CFG_EN];

	// Descriptor index from mode, endpoint, direction and pointer
	function [5:0] bd_index_of;
		input [1:0] m;
		input [3:0] ep;
		input dir_in;
		input odd;
		reg [6:0] n2;
		reg [6:0] r;
		begin
			n2 = {2'b00, ep, 1'b0};
			r = 7'h00;
			case (m)
				`UBD_MODE_NONE: begin
					r = {2'b00, ep, dir_in};
				end
				`UBD_MODE_EP0OUT: begin
					if (ep == 4'h0) begin
						r = dir_in ? 7'h02 : {6'h00, odd};
					end else begin
						r = n2 + 7'h01 + {6'h00, dir_in};
					end
				end
				`UBD_MODE_ALL: begin
					r = {1'b0, ep, dir_in, odd};
				end
				default: begin
					if (ep == 4'h0) begin
						r = {6'h00, dir_in};
					end else begin
						r = {n2[5:0], 1'b0} - 7'h02 + {5'h00, dir_in, odd};
					end
				end
			endcase
			bd_index_of = r[5:0];
		end
	endfunction

	// Whether a direction has an even/odd pair in the mode
	function has_pair;
		input [1:0] m;
		input [3:0] ep;
		input dir_in;
		begin
			case (m)
				`UBD_MODE_NONE: has_pair = 1'b0;
				`UBD_MODE_EP0OUT: has_pair = (ep == 4'h0) & ~dir_in;
				`UBD_MODE_ALL: has_pair = 1'b1;
				default: has_pair = (ep != 4'h0);
			endcase
		end
	endfunction

	// Index lookup for an incoming token
	wire tok_pp = has_pair(mode, tok_ep, tok_in);
	wire tok_ptr = tok_in ? ptr_in[tok_ep] : ptr_out[tok_ep];
	wire tok_odd = tok_ptr & tok_pp;
	wire [5:0] tok_idx = bd_index_of(mode, tok_ep, tok_in, tok_odd);

	// Current descriptor as seen by the engine
	wire [31:0] cur = descriptor_table[t_idx];
	wire [7:0] cur_st = cur[`UBD_W_STATUS];
	wire [9:0] cur_len = {cur_st[`UBD_ST_CNTH], cur[`UBD_W_COUNT]};

	// Decision made in the look cycle
	reg [1:0] next_hs;
	reg next_wb;
	reg next_release;
	reg [31:0] next_word;
	reg [9:0] new_len;
	reg tog_bad;
	always @* begin
		next_hs = `UBD_HS_ACK;
		next_wb = 1'b0;
		next_release = 1'b0;
		new_len = t_in ? cur_len : t_rx;
		tog_bad = cur_st[`UBD_ST_CHK] & ~t_setup & (t_tog != cur_st[`UBD_ST_TOG]);
		next_word = cur;
		// Engine result: owner, untouched bit six, token, length
		next_word[`UBD_ST_OWN] = cur_st[`UBD_ST_KEEP];
		next_word[`UBD_ST_TOG] = cur_st[`UBD_ST_TOG];
		next_word[`UBD_ST_PID] = t_pid;
		next_word[`UBD_ST_CNTH] = new_len[9:8];
		next_word[`UBD_W_COUNT] = new_len[7:0];
		if (!cur_st[`UBD_ST_OWN]) begin
			// CPU still holds the descriptor
			next_hs = `UBD_HS_NAK;
		end else if (cur_st[`UBD_ST_HALT] && !t_setup) begin
			// Halted: descriptor left as is
			next_hs = `UBD_HS_STALL;
		end else if (!t_in && t_err) begin
			next_hs = `UBD_HS_NAK;
		end else if (!t_in && (t_rx > cur_len)) begin
			next_hs = `UBD_HS_NAK;
		end else if (!t_in && tog_bad) begin
			// Wrong toggle: acknowledged, data dropped, still owned
			next_hs = `UBD_HS_ACK;
		end else begin
			next_hs = `UBD_HS_ACK;
			next_wb = 1'b1;
			next_release = ~cur_st[`UBD_ST_KEEP];
			if (t_setup && cur_st[`UBD_ST_HALT]) begin
				// Setup overrides a halt and returns the descriptor
				next_word[`UBD_ST_OWN] = 1'b0;
				next_release = 1'b1;
			end
		end
	end

	// Engine sequencer: take token, look up, write back
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= `UBD_S_IDLE;
			tok_ready <= 1'b0;
			t_ep <= 4'h0;
			t_pid <= 4'h0;
			t_in <= 1'b0;
			t_setup <= 1'b0;
			t_rx <= 10'h000;
			t_tog <= 1'b0;
			t_err <= 1'b0;
			t_idx <= 6'h00;
			t_odd <= 1'b0;
			t_pp <= 1'b0;
			wb_do <= 1'b0;
			wb_word <= 32'h0000_0000;
			wb_release <= 1'b0;
			hs_valid <= 1'b0;
			hs_code <= `UBD_HS_ACK;
			bd_index <= 6'h00;
			bd_addr <= 16'h0000;
			bd_len <= 10'h000;
			bd_addr_step_disable <= 1'b0;
		end else begin
			hs_valid <= 1'b0;
			case (state)
				`UBD_S_IDLE: begin
					tok_ready <= 1'b1;
					if (tok_valid && tok_ready) begin
						tok_ready <= 1'b0;
						t_ep <= tok_ep;
						t_pid <= tok_pid;
						t_in <= tok_in;
						t_setup <= tok_setup;
						t_rx <= rx_count;
						t_tog <= rx_toggle;
						t_err <= rx_error;
						t_idx <= tok_idx;
						t_odd <= tok_odd;
						t_pp <= tok_pp;
						state <= `UBD_S_LOOK;
					end
				end
				`UBD_S_LOOK: begin
					hs_valid <= 1'b1;
					hs_code <= next_hs;
					bd_index <= t_idx;
					bd_addr <= cur[`UBD_W_ADDR];
					bd_len <= new_len;
					bd_addr_step_disable <= cur_st[`UBD_ST_STEP];
					wb_do <= next_wb;
					wb_word <= next_word;
					wb_release <= next_release;
					state <= `UBD_S_WB;
				end
				`UBD_S_WB: begin
					// A bus write this cycle wins; retry next cycle
					if (!apb_wr) begin
						wb_do <= 1'b0;
						state <= `UBD_S_IDLE;
					end
				end
				default: begin
					state <= `UBD_S_IDLE;
				end
			endcase
		end
	end

	// Descriptor table writes from engine and bus
	always @(posedge pclk) begin
		if (apb_wr && in_bdt) begin
			if (pstrb[0]) descriptor_table[apb_idx][7:0] <= pwdata[7:0];
			if (pstrb[1]) descriptor_table[apb_idx][15:8] <= pwdata[15:8];
			if (pstrb[2]) descriptor_table[apb_idx][23:16] <= pwdata[23:16];
			if (pstrb[3]) descriptor_table[apb_idx][31:24] <= pwdata[31:24];
		end else if (state == `UBD_S_WB && wb_do) begin
			descriptor_table[t_idx] <= wb_word;
		end
	end

	// Released transaction: engine finished write-back
	wire release_now = (state == `UBD_S_WB) & wb_do & wb_release & ~apb_wr;

	// Pointers: cleared on enable or reset bit, flipped on release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_out <= {NUM_EP{1'b0}};
			ptr_in <= {NUM_EP{1'b0}};
		end else if (cfg_en_rise) begin
			ptr_out <= {NUM_EP{1'b0}};
			ptr_in <= {NUM_EP{1'b0}};
		end else if (cfg[`UBD_CFG_PTR_RST]) begin
			ptr_out <= {NUM_EP{1'b0}};
			ptr_in <= {NUM_EP{1'b0}};
		end else if (release_now && t_pp) begin
			if (t_in) begin
				ptr_in[t_ep] <= ~ptr_in[t_ep];
			end else begin
				ptr_out[t_ep] <= ~ptr_out[t_ep];
			end
		end
	end

	// Transfer status of the last released transaction
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xs_ep <= 4'h0;
			xs_dir <= 1'b0;
			xs_parity <= 1'b0;
		end else if (release_now) begin
			xs_ep <= t_ep;
			xs_dir <= t_in;
			xs_parity <= t_odd;
		end
	end

	// Configuration register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= `UBD_CFG_RESET;
		end else if (apb_wr && hit_cfg && pstrb[0]) begin
			cfg <= pwdata[3:0];
		end
	end

	// Read data mux
	reg [31:0] next_prdata;
	always @* begin
		next_prdata = 32'h0000_0000;
		if (in_bdt) begin
			next_prdata = descriptor_table[apb_idx];
		end else if (hit_cfg) begin
			next_prdata = {28'h0000000, cfg};
		end else if (hit_xs) begin
			next_prdata = {25'h0000000, xs_ep, xs_dir, xs_parity, 1'b0};
		end else if (hit_ptr) begin
			next_prdata = {ptr_in, ptr_out};
		end
	end

	// APB slave: one wait state, registered answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= ~mapped;
			prdata <= pwrite ? 32'h0000_0000 : next_prdata;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

// >>> tb/ubd_monitor.sv
// Purpose: Port checker for the buffer descriptor block
// Assumes: Mode only changes by bus writes between tokens
// Notes: Token fields are read two edges back at the answer
module ubd_monitor (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	input wire pready,
	input wire pslverr,
	input wire tok_valid,
	input wire [3:0] tok_ep,
	input wire tok_in,
	input wire [9:0] rx_count,
	input wire tok_ready,
	input wire hs_valid,
	input wire [1:0] hs_code,
	input wire [5:0] bd_index,
	input wire [9:0] bd_len
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [1:0] mode; // Mode as last written
	// Follow configuration writes
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			mode <= 2'h0;
		else if (psel && penable && pready && pwrite && paddr == 12'h100 && pstrb[0])
			mode <= pwdata[1:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_take;
		tok_valid && tok_ready;
	endsequence
	sequence s_beat;
		!pready ##1 pready ##1 !pready;
	endsequence
	property p_ans;
		s_take |=> !hs_valid ##1 hs_valid;
	endproperty
	property p_busy;
		s_take |=> !tok_ready [*3];
	endproperty
	property p_pulse;
		hs_valid |=> !hs_valid;
	endproperty
	property p_len;
		(tok_valid && tok_ready && !tok_in) ##2 (hs_code == 2'h0) |-> bd_len == $past(rx_count, 2);
	endproperty
	property p_m0;
		hs_valid && mode == 2'h0 |-> bd_index == {1'b0, $past(tok_ep, 2), $past(tok_in, 2)};
	endproperty
	property p_m1;
		hs_valid && mode == 2'h1 && $past(tok_ep, 2) != 4'h0
			|-> bd_index == {1'b0, $past(tok_ep, 2), $past(tok_in, 2)} + 6'h1;
	endproperty
	property p_m2;
		hs_valid && mode == 2'h2 |-> bd_index[5:1] == {$past(tok_ep, 2), $past(tok_in, 2)};
	endproperty
	property p_m3;
		hs_valid && mode == 2'h3 && $past(tok_ep, 2) == 4'h0
			|-> bd_index == {5'h0, $past(tok_in, 2)};
	endproperty
	property p_apb;
		psel && $rose(penable) |-> s_beat;
	endproperty
	property p_err;
		pready |-> pslverr == !(paddr[11:8] == 4'h0 || paddr == 12'h100 || paddr == 12'h104
			|| paddr == 12'h108);
	endproperty
	a_ans: assert property (p_ans) else $error("answer late");
	a_busy: assert property (p_busy) else $error("ready too soon");
	a_pulse: assert property (p_pulse) else $error("answer too long");
	a_len: assert property (p_len) else $error("out length");
	a_m0: assert property (p_m0) else $error("mode 0 index");
	a_m1: assert property (p_m1) else $error("mode 1 index");
	a_m2: assert property (p_m2) else $error("mode 2 index");
	a_m3: assert property (p_m3) else $error("mode 3 index");
	a_apb: assert property (p_apb) else $error("bus wait state");
	a_err: assert property (p_err) else $error("bus error flag");
endmodule
bind ubd_core ubd_monitor u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
	.tok_valid(tok_valid), .tok_ep(tok_ep), .tok_in(tok_in), .rx_count(rx_count),
	.tok_ready(tok_ready), .hs_valid(hs_valid), .hs_code(hs_code), .bd_index(bd_index),
	.bd_len(bd_len)
);

// >>> tb/ubd_host.sv
// Purpose: Bus host model feeding tokens to the engine port
// Assumes: One token at a time, held until taken
// Notes: Released endpoint, direction and count are inverted so stale values never match
module ubd_host (
	input wire pclk,
	input wire tok_ready,
	output logic tok_valid = 1'b0,
	output logic [3:0] tok_ep = 4'h0,
	output logic [3:0] tok_pid = 4'h0,
	output logic tok_in = 1'b0,
	output logic tok_setup = 1'b0,
	output logic [9:0] rx_count = 10'h0,
	output logic rx_toggle = 1'b0,
	output logic rx_error = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Raise a token, hold it until taken, then scramble
	task automatic send(input logic [3:0] ep, pid, input logic i, input logic [9:0] rx,
		input logic tg, input logic er, input logic st);
		@(posedge pclk);
		tok_valid <= 1'b1;
		tok_setup <= st; // Setup token, always with OUT direction
		rx_error <= er; // Damaged data packet
		tok_ep <= ep;
		tok_pid <= pid;
		tok_in <= i;
		rx_count <= rx;
		rx_toggle <= tg;
		do @(posedge pclk); while (tok_ready !== 1'b1);
		tok_valid <= 1'b0;
		tok_ep <= ~ep;
		tok_in <= ~i;
		rx_count <= ~rx;
	endtask
endmodule

// >>> tb/usb_buffer_descriptor_logic_tb_top.sv
// Purpose: Self-checking bench for the buffer descriptor block
// Assumes: Host model drives the engine side
// Notes: Drivers queue expectations, watchers compare
module usb_buffer_descriptor_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic [3:0] pstrb = 0, tok_ep, tok_pid;
	logic pready, pslverr, tok_valid, tok_in, tok_setup, rx_toggle, rx_error;
	logic tok_ready, hs_valid, bd_step;
	logic [9:0] rx_count, bd_len, r;
	logic [1:0] hs_code;
	logic [5:0] bd_index;
	logic [15:0] bd_addr, ad;
	logic [32:0] rq[$];
	logic [35:0] hq[$], e;
	int error_cnt = 0, tests_run = 0, m;
	ubd_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tok_valid(tok_valid), .tok_ep(tok_ep),
		.tok_pid(tok_pid), .tok_in(tok_in), .tok_setup(tok_setup), .rx_count(rx_count),
		.rx_toggle(rx_toggle), .rx_error(rx_error), .tok_ready(tok_ready),
		.hs_valid(hs_valid), .hs_code(hs_code), .bd_index(bd_index), .bd_addr(bd_addr),
		.bd_len(bd_len), .bd_addr_step_disable(bd_step));
	ubd_host host (.pclk(pclk), .tok_ready(tok_ready), .tok_valid(tok_valid),
		.tok_ep(tok_ep), .tok_pid(tok_pid), .tok_in(tok_in), .tok_setup(tok_setup),
		.rx_count(rx_count), .rx_toggle(rx_toggle), .rx_error(rx_error));
	initial forever #25 pclk = ~pclk;
	task automatic chk(input logic [63:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One bus transfer, held until ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		rq.push_back(x);
		apb(0, a, 0, 0);
	endtask
	// Own buffer per descriptor in USB RAM; the long IN buffer ends below the rest
	function automatic logic [15:0] ba(input int i);
		return ad + 16'(i < 4 ? i * 32 : 512 + i * 32);
	endfunction
	task automatic arm(input int i, input logic [7:0] st, c);
		apb(1, 12'(i * 4), {ba(i), c, 8'h00}, 4'he);
		apb(1, 12'(i * 4), {24'h0, st}, 4'h1);
	endtask
	task automatic tok(input logic [3:0] ep, pid, input logic i, input logic [9:0] rx,
		input logic tg, input logic [34:0] x, input logic er = 1'b0,
		input logic st = 1'b0, input logic sd = 1'b0);
		hq.push_back({sd, x});
		host.send(ep, pid, i, rx, tg, er, st);
		@(posedge pclk iff hs_valid);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Result watchers
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, rq.pop_front());
		if (hs_valid) begin
			e = hq.pop_front();
			chk({hs_code, bd_index, e[34] ? {bd_len, bd_addr} : e[25:0]}, e[33:0]);
			if (e[34])
				chk(bd_step, e[35]);
		end
	end
	initial begin
		void'($urandom(51583));
		ad = 16'h0400 + 16'($urandom_range(31));
		r = 10'($urandom_range(16));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		for (m = 0; m < 10; m++)
			apb(1, 12'(m * 4), 32'h0, 4'hf);
		apb(1, 12'h100, 32'h4, 4'h1);
		arm(2, 8'hc0, 8'h10);
		tok(1, 4'h1, 0, r, 0, {3'b100, 6'd2, r, ba(2)});
		rd(12'h8, {1'b0, ba(2), r[7:0], 2'b01, 4'h1, r[9:8]});
		arm(2, 8'h80, 8'h04);
		tok(1, 4'h1, 0, 10'h5, 0, {3'b001, 6'd2, 26'h0});
		rd(12'h8, {1'b0, ba(2), 8'h04, 8'h80});
		// Damaged packet: refused, descriptor untouched
		arm(2, 8'h80, 8'h10);
		tok(1, 4'h1, 0, r, 0, {3'b001, 6'd2, 26'h0}, 1'b1);
		rd(12'h8, {1'b0, ba(2), 8'h10, 8'h80});
		arm(2, 8'h88, 8'h10);
		tok(1, 4'h1, 0, r, 1, {3'b000, 6'd2, 26'h0});
		rd(12'h8, {1'b0, ba(2), 8'h10, 8'h88});
		// Keep and step-disable: written back, still owned
		arm(2, 8'hb0, 8'h10);
		tok(1, 4'h1, 0, r, 0, {3'b100, 6'd2, r, ba(2)}, 1'b0, 1'b0, 1'b1);
		rd(12'h8, {1'b0, ba(2), r[7:0], 8'h84});
		arm(2, 8'h84, 8'h10);
		tok(1, 4'h1, 0, r, 0, {3'b010, 6'd2, 26'h0});
		rd(12'h8, {1'b0, ba(2), 8'h10, 8'h84});
		// Setup on a halted descriptor hands it back
		tok(1, 4'hd, 0, r, 0, {3'b100, 6'd2, r, ba(2)}, 1'b0, 1'b1);
		rd(12'h8, {1'b0, ba(2), r[7:0], 8'h34});
		arm(3, 8'h81, 8'hff);
		tok(1, 4'h9, 1, 0, 0, {3'b100, 6'd3, 10'h1ff, ba(3)});
		rd(12'hc, {1'b0, ba(3), 8'hff, 8'h25});
		rd(12'h200, {1'b1, 32'h0});
		apb(1, 12'h100, 32'h2, 4'h1);
		apb(1, 12'h100, 32'h6, 4'h1);
		arm(8, 8'h80, 8'h10);
		arm(9, 8'h80, 8'h10);
		tok(2, 4'h1, 0, r, 0, {3'b100, 6'd8, r, ba(8)});
		tok(2, 4'h1, 0, r, 0, {3'b100, 6'd9, r, ba(9)});
		rd(12'h104, {1'b0, 32'h12});
		// Leave the OUT pointer of endpoint 2 on odd
		arm(8, 8'h80, 8'h10);
		tok(2, 4'h1, 0, r, 0, {3'b100, 6'd8, r, ba(8)});
		rd(12'h104, {1'b0, 32'h10});
		rd(12'h108, {1'b0, 32'h4});
		apb(1, 12'h100, 32'he, 4'h1);
		apb(1, 12'h100, 32'h6, 4'h1);
		arm(8, 8'h80, 8'h10);
		tok(2, 4'h1, 0, r, 0, {3'b100, 6'd8, r, ba(8)});
		// Pointer odd again; enabling the module must clear it
		apb(1, 12'h100, 32'h2, 4'h1);
		apb(1, 12'h100, 32'h6, 4'h1);
		arm(8, 8'h80, 8'h10);
		tok(2, 4'h1, 0, r, 0, {3'b100, 6'd8, r, ba(8)});
		for (m = 0; m < 4; m++) begin
			apb(1, 12'h100, 32'(4 + m), 4'h1);
			tok(1, 4'h9, 1, 0, 0, {3'b001, 6'(m == 0 ? 3 : m == 2 ? 6 : 4), 26'h0});
			tok(0, 4'h1, 0, 0, 0, {3'b001, 32'h0});
		end
		test_done();
	end
	initial begin
		#100us;
		error_cnt++;
		test_done();
	end
endmodule
